// ### include/link_cycle_map.vh
`ifndef LINK_CYCLE_MAP_VH
`define LINK_CYCLE_MAP_VH
// Register byte offsets
`define ADDR_PRIORITY_BUDGET  8'hDC
`define ADDR_FLAGS_SET        8'hE0
`define ADDR_FLAGS_CLEAR      8'hE4
// Flag bit positions
`define BIT_ROLLOVER_SOURCE   22
`define BIT_ROOT_CYCLE_START  21
`define BIT_COUNT_ENABLE      20
`define BIT_ACCEPT_PHY        10
`define BIT_ACCEPT_IDENTITY   9
`define BIT_SYNC_FORCE        6
// Writable flag mask
`define FLAGS_MASK            32'h00700640
// Reset values
`define BUDGET_RESET          8'h00
`define FLAGS_RESET           32'h00000000
// Cycle period in cycles of the 24.576 MHz clock
`define CYCLE_PERIOD_TICKS    12'd3072
`define CYCLE_OFFSET_LAST     12'd3071
`endif

// ### rtl/edge_sync.v
// Two-stage synchroniser with a rising-edge pulse taken from the second stage and a third flop
module edge_sync (
  input  wire clock,
  input  wire reset,
  input  wire async_in,
  output reg  rise_pulse
);
  reg meta_q;
  reg stable_q;
  reg prev_q;

  // Synchroniser stages and edge detector
  always @(posedge clock) begin
    if (reset) begin
      meta_q     <= 1'b0;
      stable_q   <= 1'b0;
      prev_q     <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      meta_q     <= async_in;
      stable_q   <= meta_q;
      prev_q     <= stable_q;
      rise_pulse <= stable_q & ~prev_q;
    end
  end
endmodule // edge_sync

// ### rtl/link_cycle_and_fairness_ctrl.v
// What this block does
// (R1) Hold 8-bit priority request limit, reset to zero, capping requests per fairness interval.
// (R2) Fairness register bits 31 to 8 always read as zero.
// (R3) Link flags reachable at a set address E0h and a clear address E4h.
// (R4) Ones set at set address, ones clear at clear address; reads show flags.
// (R5) Rollover source flag one: cycle timer rolls over on external input events.
// (R6) Rollover source flag zero: roll over after 3072 ticks of 24.576 MHz.
// (R7) Root flag one: emit cycle start request on every rollover.
// (R8) Root flag zero: accept received cycle starts to stay synchronised.
// (R9) Root flag cleared automatically when overlong cycle event becomes set.
// (R10) Setting root flag is ignored while overlong cycle event stays set.
// (R11) Count enable set: offset advances each tick and rolls over; clear: holds.
// (R12) PHY packet flag and receive context enabled: store incoming PHY packets.
// (R13) Identity flag one: accept node identity packets, else refuse them.
// (R14) Software loads identity buffer pointer before setting identity accept flag.
// (R15) Sync force flag one forces sync filter bit in every receive context.
// (R16) Sync force flag is set by software, cleared only by global hardware reset.
// (R17) Reserved link flag bits read back as zero at both addresses.
//
// Register map, byte offsets on a 32-bit word bus:
//   DCh  priority request budget, bits 7..0, upper bits read as zero
//   E0h  link flags, write ones to set, read current flags
//   E4h  link flags, write ones to clear, read current flags
// Link flag positions:
//   22   rollover source, external input when one
//   21   root, request a cycle start on every rollover
//   20   offset counter enable
//   10   store PHY packets into the async receive request context
//    9   accept node identity packets
//    6   sync filter force, sticky until the global hardware reset pin
// Hazards:
//   The tick and the external rollover, overlong and global reset pins come from other clocks and pass two flops first,
//   so a rollover from the external input lands a few clocks after its edge.
//   Read data come from next-state values, so a read issued in the data
//   phase of a write already sees that write.
`include "link_cycle_map.vh"
module link_cycle_and_fairness_ctrl (
  input  wire        clock,
  input  wire        reset,
  input  wire        global_hw_reset,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Cycle timer
  input  wire        tick_24m,
  input  wire        external_rollover_input,
  input  wire        overlong_cycle_event,
  input  wire        cycle_start_received,
  input  wire [11:0] cycle_start_offset,
  output reg  [11:0] cycle_offset,
  output reg  [6:0]  cycle_count,
  output reg         cycle_start_request,
  // Receiver filters
  input  wire        async_receive_enabled,
  input  wire        phy_packet_arrived,
  input  wire        identity_packet_arrived,
  input  wire        iso_sync_filter_bit_sw,
  output reg         store_phy_packet,
  output reg         accept_identity_packet,
  output reg         iso_sync_filter_bit,
  // Static flag views
  output reg  [7:0]  priority_request_limit,
  output reg         rollover_source_select,
  output reg         root_cycle_start_gen,
  output reg         offset_count_enable,
  output reg         accept_phy_packets,
  output reg         accept_node_identity_packets,
  output reg         sync_filter_force
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Writable flags after a write through set or clear address
  function [31:0] apply_flags;
    input [31:0] cur;
    input [31:0] data;
    input        is_set;
    begin
      if (is_set)
        apply_flags = (cur | data) & `FLAGS_MASK;
      else
        apply_flags = cur & ~(data & `FLAGS_MASK);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire ext_rise;
  reg  tick_meta_q;
  reg  tick_q;
  reg  tick_prev_q;
  reg  ovl_meta_q;
  reg  ovl_q;
  reg  ovl_prev_q;
  reg  ghr_meta_q;
  reg  ghr_q;

  // External rollover pin edge
  edge_sync ext_sync (
    .clock      (clock),
    .reset      (reset),
    .async_in   (external_rollover_input),
    .rise_pulse (ext_rise)
  );

  // Two-flop stages for the tick, overlong event and global reset
  // A third flop on tick and overlong gives a one-clock rising-edge pulse;
  // only the second and third stages feed any logic, never the first
  always @(posedge clock) begin
    if (reset) begin
      tick_meta_q <= 1'b0;
      tick_q      <= 1'b0;
      tick_prev_q <= 1'b0;
      ovl_meta_q  <= 1'b0;
      ovl_q       <= 1'b0;
      ovl_prev_q  <= 1'b0;
      ghr_meta_q  <= 1'b0;
      ghr_q       <= 1'b0;
    end else begin
      tick_meta_q <= tick_24m;
      tick_q      <= tick_meta_q;
      tick_prev_q <= tick_q;
      ovl_meta_q  <= overlong_cycle_event;
      ovl_q       <= ovl_meta_q;
      ovl_prev_q  <= ovl_q;
      ghr_meta_q  <= global_hw_reset;
      ghr_q       <= ghr_meta_q;
    end
  end

  wire tick_rise = tick_q & ~tick_prev_q;
  wire ovl_rise  = ovl_q & ~ovl_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address and data phase

  reg        ph_valid_q;
  reg        ph_write_q;
  reg [7:0]  ph_addr_q;

  wire take = hsel & hready & htrans[1];

  // Latch address phase; slave is always ready with OKAY
  // Zero wait states: a write lands at the end of its data phase, and the
  // address phase is captured only while the bus is ready
  always @(posedge clock) begin
    if (reset) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      if (hready) begin
        ph_valid_q <= take;
        ph_write_q <= hwrite;
        ph_addr_q  <= haddr[7:0];
      end
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  wire wr_now   = ph_valid_q & ph_write_q;
  wire wr_budget = wr_now & (ph_addr_q == `ADDR_PRIORITY_BUDGET);
  wire wr_set   = wr_now & (ph_addr_q == `ADDR_FLAGS_SET);   // see (R3)
  wire wr_clr   = wr_now & (ph_addr_q == `ADDR_FLAGS_CLEAR); // see (R3)

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg  [7:0]  budget_q;
  reg  [7:0]  budget_d;
  reg  [31:0] flags_q;
  reg  [31:0] flags_d;
  reg         sync_force_q;
  reg         sync_force_d;

  // Next value of the budget
  always @* begin
    budget_d = budget_q;
    if (wr_budget)
      budget_d = hwdata[7:0]; // see (R1)
  end

  // Next value of the set/clear flags
  always @* begin
    flags_d = flags_q;
    if (wr_set)
      flags_d = apply_flags(flags_q, hwdata, 1'b1); // see (R4)
    else if (wr_clr)
      flags_d = apply_flags(flags_q, hwdata, 1'b0); // see (R4)
    flags_d[`BIT_SYNC_FORCE] = 1'b0;
    if (ovl_q & wr_set & ~flags_q[`BIT_ROOT_CYCLE_START])
      flags_d[`BIT_ROOT_CYCLE_START] = 1'b0; // see (R10)
    if (ovl_rise)
      flags_d[`BIT_ROOT_CYCLE_START] = 1'b0; // see (R9)
  end

  // Budget and flag registers
  always @(posedge clock) begin
    if (reset) begin
      budget_q <= `BUDGET_RESET; // see (R1)
      flags_q  <= `FLAGS_RESET;
    end else begin
      budget_q <= budget_d; // see (R1)
      flags_q  <= flags_d;
    end
  end

  // Next value of the sync force lock; the hardware reset pin wins over a set
  // The clear address has no path here, so the lock cannot be dropped by software
  always @* begin
    sync_force_d = sync_force_q;
    if (ghr_q)
      sync_force_d = 1'b0; // see (R16)
    else if (wr_set & hwdata[`BIT_SYNC_FORCE])
      sync_force_d = 1'b1; // see (R16)
  end

  // Sync force lock register
  always @(posedge clock) begin
    if (reset)
      sync_force_q <= 1'b0;
    else
      sync_force_q <= sync_force_d; // see (R16)
  end

  // Read view of the next flag state, so a read right behind a write sees it
  wire [31:0] flags_view = flags_d | ({31'h0, sync_force_d} << `BIT_SYNC_FORCE);

  // Read data for the next data phase
  always @(posedge clock) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      case (haddr[7:0])
        `ADDR_PRIORITY_BUDGET: hrdata <= {24'h000000, budget_d};  // see (R2)
        `ADDR_FLAGS_SET:       hrdata <= flags_view & `FLAGS_MASK; // see (R17)
        `ADDR_FLAGS_CLEAR:     hrdata <= flags_view & `FLAGS_MASK; // see (R17)
        default:               hrdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timer

  wire src_ext = flags_q[`BIT_ROLLOVER_SOURCE];
  wire root    = flags_q[`BIT_ROOT_CYCLE_START];
  wire cnt_en  = flags_q[`BIT_COUNT_ENABLE];
  wire int_roll = tick_rise & (cycle_offset == `CYCLE_OFFSET_LAST);
  wire roll    = cnt_en & (src_ext ? ext_rise : int_roll); // see (R5) (R6)

  // Offset counter, cycle count and cycle start request
  // A received cycle start only loads the offset when this node is not root;
  // the external source still needs the count enable before it rolls over.
  // Counting stops at the last offset value: a tick there rolls it to zero on the internal source and leaves it there on the external one.
  always @(posedge clock) begin
    if (reset) begin
      cycle_offset        <= 12'h000;
      cycle_count         <= 7'h00;
      cycle_start_request <= 1'b0;
    end else begin
      cycle_start_request <= roll & root; // see (R7)
      if (~root & cycle_start_received) begin
        cycle_offset <= cycle_start_offset; // see (R8)
      end else if (roll) begin
        cycle_offset <= 12'h000; // see (R11)
        cycle_count  <= cycle_count + 7'h01;
      end else if (cnt_en & tick_rise & (cycle_offset != `CYCLE_OFFSET_LAST)) begin
        cycle_offset <= cycle_offset + 12'h001; // see (R11)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver filters and flag views

  // Registered filter decisions and flag outputs
  // Each output is one clock behind the storage it shows, so every top-level
  // output comes from a flop
  always @(posedge clock) begin
    if (reset) begin
      store_phy_packet             <= 1'b0;
      accept_identity_packet       <= 1'b0;
      iso_sync_filter_bit          <= 1'b0;
      priority_request_limit       <= 8'h00;
      rollover_source_select       <= 1'b0;
      root_cycle_start_gen         <= 1'b0;
      offset_count_enable          <= 1'b0;
      accept_phy_packets           <= 1'b0;
      accept_node_identity_packets <= 1'b0;
      sync_filter_force            <= 1'b0;
    end else begin
      store_phy_packet       <= phy_packet_arrived & async_receive_enabled &
                                flags_q[`BIT_ACCEPT_PHY];                      // see (R12)
      accept_identity_packet <= identity_packet_arrived & flags_q[`BIT_ACCEPT_IDENTITY]; // see (R13)
      iso_sync_filter_bit    <= sync_force_q | iso_sync_filter_bit_sw;       // see (R15)
      priority_request_limit       <= budget_q;
      rollover_source_select       <= src_ext;
      root_cycle_start_gen         <= root;
      offset_count_enable          <= cnt_en;
      accept_phy_packets           <= flags_q[`BIT_ACCEPT_PHY];
      accept_node_identity_packets <= flags_q[`BIT_ACCEPT_IDENTITY];
      sync_filter_force            <= sync_force_q;
    end
  end

endmodule // link_cycle_and_fairness_ctrl

// ### tb/link_cycle_checker.sv
module link_cycle_checker (
  input logic        clock, reset, global_hw_reset, hsel, hwrite, hreadyout, hresp,
  input logic [31:0] haddr, hrdata,
  input logic [1:0]  htrans,
  input logic [11:0] cycle_offset,
  input logic        overlong_cycle_event, cycle_start_received, async_receive_enabled,
  input logic        phy_packet_arrived, identity_packet_arrived, store_phy_packet,
  input logic        accept_identity_packet, iso_sync_filter_bit, root_cycle_start_gen,
  input logic        offset_count_enable, accept_phy_packets, accept_node_identity_packets,
  input logic        sync_filter_force
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Read taken on this edge
  wire rd_taken = hsel && hreadyout && htrans[1] && !hwrite;
  ////////////////////////////////////////////////////////////////////////
  // Bus, reserved bits, filters, lock, timer
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_budget_zeros: assert property (rd_taken && haddr == 32'hDC |=> hrdata[31:8] == 24'h0)
    else $error("budget upper bits not zero");
  a_flags_zeros: assert property (rd_taken && haddr[31:3] == 29'h1C |=> (hrdata & 32'hFF8FF9BF) == 32'h0)
    else $error("reserved flag bits not zero");
  a_identity_refused: assert property (identity_packet_arrived ##1 !accept_node_identity_packets |-> !accept_identity_packet)
    else $error("identity packet accepted while off");
  a_phy_stored: assert property (phy_packet_arrived && async_receive_enabled ##1 accept_phy_packets |-> store_phy_packet)
    else $error("phy packet not stored");
  a_lock_forces: assert property (sync_filter_force ##1 sync_filter_force |-> iso_sync_filter_bit)
    else $error("sync filter bit not forced");
  a_lock_sticky: assert property (sync_filter_force && !global_hw_reset && !$past(global_hw_reset) && !$past(global_hw_reset, 2)
    && !$past(global_hw_reset, 3) && !$past(global_hw_reset, 4) |=> sync_filter_force)
    else $error("lock cleared without hardware reset");
  a_offset_holds: assert property (!cycle_start_received ##1 !offset_count_enable |-> $stable(cycle_offset))
    else $error("offset moved while disabled");
  a_offset_max: assert property (cycle_offset <= 12'hBFF)
    else $error("offset beyond last value");
  a_overlong_clears: assert property (overlong_cycle_event [*8] |=> !root_cycle_start_gen)
    else $error("root flag kept during overlong event");
endmodule // link_cycle_checker

bind link_cycle_and_fairness_ctrl link_cycle_checker i_link_cycle_checker (.*);

// ### tb/link_tick_model.sv
module link_tick_model #(
  parameter real HALF_NS = 50.0
) (
  output logic tick_24m
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow free-running tick, off the bench clock edges so 40 MHz sampling sees every edge
  initial begin
    tick_24m = 1'b0;
    #3;
    forever #(HALF_NS) tick_24m = ~tick_24m;
  end
endmodule // link_tick_model

// ### tb/tb_link_cycle_and_fairness_ctrl.sv
`include "link_cycle_map.vh"
module tb_link_cycle_and_fairness_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, reset = 1'b1, global_hw_reset = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        external_rollover_input = 1'b0, overlong_cycle_event = 1'b0, cycle_start_received = 1'b0;
  logic        async_receive_enabled = 1'b0, phy_packet_arrived = 1'b0, identity_packet_arrived = 1'b0;
  logic        iso_sync_filter_bit_sw = 1'b0, hready, hreadyout, hresp, tick_24m, cycle_start_request;
  logic [11:0] cycle_start_offset = 12'h0, cycle_offset;
  logic [6:0]  cycle_count, cc;
  logic [7:0]  priority_request_limit;
  logic        store_phy_packet, accept_identity_packet, iso_sync_filter_bit, rollover_source_select;
  logic        root_cycle_start_gen, offset_count_enable, accept_phy_packets;
  logic        accept_node_identity_packets, sync_filter_force;
  int          miscompares = 0, check_count = 0, n, ticks;
  // The one slave's ready is the bus ready
  assign hready = hreadyout;
  link_cycle_and_fairness_ctrl i_link_cycle_and_fairness_ctrl (.*);
  link_tick_model i_link_tick_model (.tick_24m(tick_24m));
  // Clock
  always #12.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  // Report and compare
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for ready at a rising edge
  task automatic wait_ready();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // One single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Count ticks up to the next cycle start request
  task automatic wait_req(input int lim);
    int  k;
    logic p;
    ticks = 0;
    @(negedge clock);
    p = tick_24m;
    for (k = 0; k < lim && cycle_start_request !== 1'b1; k++) begin
      @(negedge clock);
      ticks += int'(tick_24m && !p);
      p = tick_24m;
    end
    if (k >= lim) begin
      miscompares++;
      print_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    rchk(32'hDC, 32'h0);
    rchk(32'hE0, 32'h0);
    bus(1'b1, 32'hDC, 32'hFFFFFFFF);
    rchk(32'hDC, 32'hFF);
    chk(priority_request_limit, 32'hFF);
    bus(1'b1, 32'hF0, 32'hFFFFFFFF);
    rchk(32'hF0, 32'h0);
    $display("regs done");
  endtask
  task automatic t_flags();
    bus(1'b1, 32'hE0, 32'hFFFFFFFF);
    rchk(32'hE0, 32'h00700640);
    rchk(32'hE4, 32'h00700640);
    chk(iso_sync_filter_bit, 32'h1);
    chk({rollover_source_select, root_cycle_start_gen, offset_count_enable, accept_phy_packets,
         accept_node_identity_packets, sync_filter_force}, 32'h3F);
    bus(1'b1, 32'hE4, 32'hFFFFFFFF);
    rchk(32'hE0, 32'h40);
    global_hw_reset <= 1'b1;
    repeat (3) @(posedge clock);
    global_hw_reset <= 1'b0;
    repeat (6) @(posedge clock);
    rchk(32'hE4, 32'h0);
    chk(iso_sync_filter_bit, 32'h0);
    $display("flags done");
  endtask
  task automatic t_filters();
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, (i != 0) ? 32'hE0 : 32'hE4, 32'h600);
      @(posedge clock);
      async_receive_enabled <= (i != 1);
      phy_packet_arrived <= 1'b1;
      identity_packet_arrived <= 1'b1;
      @(posedge clock);
      phy_packet_arrived <= 1'b0;
      identity_packet_arrived <= 1'b0;
      @(negedge clock);
      chk({store_phy_packet, accept_identity_packet}, {i == 2, i != 0});
    end
    $display("filters done");
  endtask
  task automatic t_cycle();
    bus(1'b1, 32'hE0, 32'h00300000);
    wait_req(14000);
    cc = cycle_count;
    wait_req(14000);
    chk(ticks, `CYCLE_PERIOD_TICKS);
    chk(cycle_count, cc + 7'h01);
    bus(1'b1, 32'hE0, 32'h00400000);
    external_rollover_input <= 1'b1;
    wait_req(20);
    chk(cycle_offset < 12'h2, 32'h1);
    @(posedge clock);
    external_rollover_input <= 1'b0;
    $display("cycle done");
  endtask
  task automatic t_overlong();
    overlong_cycle_event <= 1'b1;
    repeat (10) @(posedge clock);
    bus(1'b1, 32'hE0, 32'h00200000);
    rchk(32'hE0, 32'h00500600);
    overlong_cycle_event <= 1'b0;
    repeat (6) @(posedge clock);
    bus(1'b1, 32'hE0, 32'h00200000);
    rchk(32'hE0, 32'h00700600);
    bus(1'b1, 32'hE4, 32'h00700000);
    cycle_start_received <= 1'b1;
    cycle_start_offset <= 12'h123;
    @(posedge clock);
    cycle_start_received <= 1'b0;
    repeat (20) @(negedge clock);
    chk(cycle_offset, 32'h123);
    $display("overlong and sync done");
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_flags();
    t_filters();
    t_cycle();
    t_overlong();
    print_verdict();
  end
endmodule // tb_link_cycle_and_fairness_ctrl
